// ===== design/sml_link.sv
`timescale 1ns/1ns
`default_nettype none
// ***************************************************
// token fifo
// ***************************************************
module sml_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 32
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic do_wr;
   logic do_rd;
   assign in_ready = count != (AW+1)'(DEPTH);
   assign out_valid = count != '0;
   assign out_data = mem[rd_ptr];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;
   always_ff @(posedge core_clk) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data;
      end
   end
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         if (do_wr && !do_rd) begin
            count <= count + 1'b1;
         end else if (do_rd && !do_wr) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

// ***************************************************
// serial message link
// ***************************************************
module sml_link #(
   parameter int DEPTH = sml_pkg::FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic rxd,
   output logic txd,
   output logic cmd_valid,
   input wire logic cmd_ready,
   output sml_pkg::sml_token_t cmd_token,
   input wire logic resp_valid,
   output logic resp_ready,
   input wire logic [6:0] resp_data,
   input wire logic resp_last,
   output logic query_pending
);
   // ***************************************************
   // receiver
   // ***************************************************
   logic rx_meta;
   logic rx_sync;
   logic rx_prev;
   sml_pkg::sml_rx_state_t rx_state;
   logic [11:0] rx_cnt;
   logic [3:0] rx_bitn;
   logic [8:0] rx_sh;
   logic char_done;
   logic [6:0] char_data;
   logic char_bad;
   logic [8:0] rx_frame;
   // meta flop feeds only the second flop
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
         rx_prev <= 1'b1;
      end else begin
         rx_meta <= rxd;
         rx_sync <= rx_meta;
         rx_prev <= rx_sync;
      end
   end
   assign rx_frame = {rx_sync, rx_sh[8:1]};
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rx_state <= sml_pkg::SML_RX_IDLE;
         rx_cnt <= 12'h000;
         rx_bitn <= 4'h0;
         rx_sh <= 9'h1FF;
         char_done <= 1'b0;
         char_data <= 7'h00;
         char_bad <= 1'b0;
      end else begin
         char_done <= 1'b0;
         case (rx_state)
            sml_pkg::SML_RX_IDLE: begin
               rx_cnt <= 12'h000;
               if (rx_prev && !rx_sync) begin
                  rx_state <= sml_pkg::SML_RX_START;
               end
            end
            sml_pkg::SML_RX_START: begin
               // mid start bit; a glitch shorter than half a bit is dropped
               if (rx_cnt == sml_pkg::HALF_CYCLES - 1'b1) begin
                  rx_cnt <= 12'h000;
                  rx_bitn <= 4'h0;
                  rx_state <= rx_sync ? sml_pkg::SML_RX_IDLE : sml_pkg::SML_RX_BITS;
               end else begin
                  rx_cnt <= rx_cnt + 1'b1;
               end
            end
            sml_pkg::SML_RX_BITS: begin
               if (rx_cnt == sml_pkg::BIT_CYCLES - 1'b1) begin
                  rx_cnt <= 12'h000;
                  rx_sh <= rx_frame;
                  rx_bitn <= rx_bitn + 1'b1;
                  if (rx_bitn == 4'(sml_pkg::DATA_BITS + 1)) begin
                     char_done <= 1'b1;
                     char_data <= rx_frame[6:0];
                     char_bad <= !rx_frame[8] || !(^rx_frame[7:0]);
                     rx_state <= sml_pkg::SML_RX_IDLE;
                  end
               end else begin
                  rx_cnt <= rx_cnt + 1'b1;
               end
            end
            default: begin
               rx_state <= sml_pkg::SML_RX_IDLE;
            end
         endcase
      end
   end

   // ***************************************************
   // message splitter
   // ***************************************************
   logic [7:0] msg_len;
   logic msg_err;
   logic msg_query;
   logic part_query;
   logic push_valid;
   logic push_ready;
   sml_pkg::sml_token_t push_token;
   logic is_lf;
   logic is_semi;
   logic is_qmark;
   logic next_err;
   logic query_done;
   assign is_lf = char_data == sml_pkg::CHAR_LF;
   assign is_semi = char_data == sml_pkg::CHAR_SEMI;
   assign is_qmark = char_data == sml_pkg::CHAR_QMARK;
   // carriage return is swallowed, so cr-lf and lone lf end alike
   assign push_valid = char_done && (char_data != sml_pkg::CHAR_CR);
   // an overrun or too long a message poisons the message, no stall
   // a swallowed cr is never pushed, so it cannot overrun
   assign next_err = msg_err || char_bad || (push_valid && !push_ready)
      || (msg_len == 8'(sml_pkg::MAX_MSG_CHARS));
   always_comb begin
      push_token.data = char_data;
      push_token.error = next_err;
      push_token.query = part_query || is_qmark;
      if (is_lf) begin
         push_token.kind = sml_pkg::SML_TOK_END;
      end else if (is_semi) begin
         push_token.kind = sml_pkg::SML_TOK_SEP;
      end else begin
         push_token.kind = sml_pkg::SML_TOK_CHAR;
      end
   end
   assign query_done = push_valid && is_lf && (msg_query || part_query) && !next_err;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         msg_len <= 8'h00;
         msg_err <= 1'b0;
         msg_query <= 1'b0;
         part_query <= 1'b0;
      end else if (char_done) begin
         if (push_valid && is_lf) begin
            msg_len <= 8'h00;
            msg_err <= 1'b0;
            msg_query <= 1'b0;
            part_query <= 1'b0;
         end else begin
            msg_len <= (msg_len == 8'hFF) ? msg_len : msg_len + 1'b1;
            msg_err <= next_err;
            if (is_semi) begin
               msg_query <= msg_query || part_query;
               part_query <= 1'b0;
            end else if (is_qmark) begin
               part_query <= 1'b1;
            end
         end
      end
   end
   sml_fifo #(
      .WIDTH(sml_pkg::TOKEN_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .nrst(nrst),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(push_token),
      .out_valid(cmd_valid),
      .out_ready(cmd_ready),
      .out_data(cmd_token)
   );
   // ***************************************************
   // transmitter
   // ***************************************************
   sml_pkg::sml_tx_state_t tx_state;
   logic [9:0] tx_sh;
   logic [11:0] tx_cnt;
   logic [3:0] tx_bitn;
   logic [1:0] tx_tail;
   logic [6:0] tx_char;
   logic tx_load;
   assign resp_ready = (tx_state == sml_pkg::SML_TX_IDLE) && query_pending
      && (tx_tail == 2'h0);
   assign tx_load = (tx_state == sml_pkg::SML_TX_IDLE) && query_pending
      && ((tx_tail == 2'h0 && resp_valid) || tx_tail == 2'h1 || tx_tail == 2'h2);
   assign tx_char = (tx_tail == 2'h1) ? sml_pkg::CHAR_CR
      : (tx_tail == 2'h2) ? sml_pkg::CHAR_LF : resp_data;
   assign txd = tx_sh[0];
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         query_pending <= 1'b0;
         tx_tail <= 2'h0;
      end else begin
         // a new query landing as the old answer ends still wins
         if (query_done) begin
            query_pending <= 1'b1;
         end else if (tx_state == sml_pkg::SML_TX_IDLE && tx_tail == 2'h3) begin
            query_pending <= 1'b0;
         end
         if (tx_state == sml_pkg::SML_TX_IDLE && tx_tail == 2'h3) begin
            tx_tail <= 2'h0;
         end else if (tx_load) begin
            tx_tail <= (tx_tail == 2'h0) ? (resp_last ? 2'h1 : 2'h0)
               : tx_tail + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tx_state <= sml_pkg::SML_TX_IDLE;
         tx_sh <= 10'h3FF;
         tx_cnt <= 12'h000;
         tx_bitn <= 4'h0;
      end else begin
         case (tx_state)
            sml_pkg::SML_TX_IDLE: begin
               tx_cnt <= 12'h000;
               tx_bitn <= 4'h0;
               if (tx_load) begin
                  tx_sh <= {1'b1, ~^tx_char, tx_char, 1'b0};
                  tx_state <= sml_pkg::SML_TX_SHIFT;
               end
            end
            sml_pkg::SML_TX_SHIFT: begin
               if (tx_cnt == sml_pkg::BIT_CYCLES - 1'b1) begin
                  tx_cnt <= 12'h000;
                  tx_sh <= {1'b1, tx_sh[9:1]};
                  tx_bitn <= tx_bitn + 1'b1;
                  if (tx_bitn == 4'(sml_pkg::DATA_BITS + 2)) begin
                     tx_state <= sml_pkg::SML_TX_IDLE;
                  end
               end else begin
                  tx_cnt <= tx_cnt + 1'b1;
               end
            end
            default: begin
               tx_state <= sml_pkg::SML_TX_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ===== pkg/sml_pkg.sv
// Functional notes
// - link is async serial at fixed 57600 bit/s, no flow control or handshake lines
// - each character: start bit, seven ascii data bits, odd parity, one stop bit
// - incoming message ends at lone line feed or carriage return then line feed
// - every transmitted response ends with carriage return then line feed
// - semicolon splits one message into parts handed on individually
// - command is mnemonic, space, parameters, terminator; instrument then acts on it
// - query carries question mark after mnemonic; question mark marks a part as query
// - response starts as soon as possible after a complete query
// - instrument never transmits unless answering a received query
`default_nettype none
package sml_pkg;
   // ***************************************************
   // timing
   // ***************************************************
   localparam int CLK_HZ = 125_000_000;
   localparam int BAUD = 57_600;
   localparam logic [11:0] BIT_CYCLES = 12'(CLK_HZ / BAUD);
   localparam logic [11:0] HALF_CYCLES = 12'(CLK_HZ / BAUD / 2);
   localparam int DATA_BITS = 7;
   localparam int MAX_MSG_CHARS = 255;
   localparam int FIFO_DEPTH = 32;
   // ***************************************************
   // characters
   // ***************************************************
   localparam logic [6:0] CHAR_LF = 7'h0A;
   localparam logic [6:0] CHAR_CR = 7'h0D;
   localparam logic [6:0] CHAR_SEMI = 7'h3B;
   localparam logic [6:0] CHAR_QMARK = 7'h3F;
   // ***************************************************
   // tokens handed to the interpreter
   // ***************************************************
   typedef enum logic [1:0] {
      SML_TOK_CHAR = 2'b00,
      SML_TOK_SEP = 2'b01,
      SML_TOK_END = 2'b10
   } sml_tok_t;
   typedef struct packed {
      sml_tok_t kind;
      logic query;
      logic error;
      logic [6:0] data;
   } sml_token_t;
   localparam int TOKEN_W = $bits(sml_token_t);
   typedef enum logic [1:0] {
      SML_RX_IDLE = 2'b00,
      SML_RX_START = 2'b01,
      SML_RX_BITS = 2'b10
   } sml_rx_state_t;
   typedef enum logic [0:0] {
      SML_TX_IDLE = 1'b0,
      SML_TX_SHIFT = 1'b1
   } sml_tx_state_t;
endpackage
`default_nettype wire

// ===== bench/sml_link_properties.sv
`timescale 1ns/1ns
`default_nettype none
module sml_link_properties (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic rxd,
   input wire logic txd,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire sml_pkg::sml_token_t cmd_token,
   input wire logic resp_valid,
   input wire logic resp_ready,
   input wire logic [6:0] resp_data,
   input wire logic resp_last,
   input wire logic query_pending
);
   localparam int BIT = int'(sml_pkg::BIT_CYCLES);
   logic txd_q;
   logic [15:0] run;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // length of the present txd level
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         txd_q <= 1'b1;
         run <= 16'h0001;
      end else begin
         txd_q <= txd;
         run <= (txd != txd_q) ? 16'h0001 : run + 16'h0001;
      end
   end
   // a pending query may only come from a message that reached the fifo
   a_no_unsolicited: assert property ($rose(query_pending) |-> cmd_valid)
      else $error("query pending without received message");
   a_quiet_line: assert property (!query_pending && !$past(query_pending) |-> txd)
      else $error("txd active without query");
   a_prompt_start: assert property (resp_valid && resp_ready |=> !txd)
      else $error("start bit late");
   a_low_run_bits: assert property (txd && !txd_q |-> (int'(run) % BIT) == 0)
      else $error("bit width wrong");
   a_one_char: assert property (resp_valid && resp_ready |=> !resp_ready [*8])
      else $error("ready inside a frame");
   a_token_holds: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_token))
      else $error("token changed");
   a_cr_dropped: assert property (cmd_valid |-> cmd_token.data != sml_pkg::CHAR_CR)
      else $error("cr token seen");
   a_ready_idle: assert property (resp_ready |-> txd && query_pending)
      else $error("ready while busy");
endmodule
bind sml_link sml_link_properties sml_link_properties_i (.core_clk(core_clk), .nrst(nrst),
   .rxd(rxd), .txd(txd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_token(cmd_token),
   .resp_valid(resp_valid), .resp_ready(resp_ready), .resp_data(resp_data),
   .resp_last(resp_last), .query_pending(query_pending));
`default_nettype wire

// ===== bench/sml_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module sml_host_model (
   input wire logic core_clk,
   output logic rxd,
   input wire logic txd
);
   localparam int BIT = int'(sml_pkg::BIT_CYCLES);
   logic [6:0] got[$];
   logic bad = 1'b0;
   initial rxd = 1'b1;
   // short messages only, one call per character, no gaps
   task automatic send_char(input logic [6:0] c);
      logic [9:0] f;
      f = {1'b1, ~^c, c, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge core_clk);
         rxd <= f[i];
         repeat (BIT - 1) @(posedge core_clk);
      end
   endtask
   // always listening, takes every frame whole
   always begin
      logic [9:0] f;
      @(negedge txd);
      repeat (BIT / 2) @(posedge core_clk);
      for (int i = 0; i < 10; i++) begin
         f[i] = txd;
         if (i < 9) repeat (BIT) @(posedge core_clk);
      end
      if (f[0] || !f[9] || !(^f[8:1])) bad = 1'b1;
      got.push_back(f[7:1]);
   end
endmodule
`default_nettype wire

// ===== bench/tb_sml_link.sv
`timescale 1ns/1ns
`default_nettype none
module tb_sml_link;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic rxd, txd, cmd_valid, resp_ready, query_pending;
   logic cmd_ready = 1'b0;
   logic resp_valid = 1'b0;
   logic resp_last = 1'b0;
   logic [6:0] resp_data = 7'h00;
   sml_pkg::sml_token_t cmd_token;
   sml_pkg::sml_token_t toks[$];
   int errors = 0;
   int checked = 0;
   int cycles = 0;
   always #4 core_clk = ~core_clk;
   sml_link sml_link_i (.core_clk(core_clk), .nrst(nrst), .rxd(rxd), .txd(txd),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_token(cmd_token),
      .resp_valid(resp_valid), .resp_ready(resp_ready), .resp_data(resp_data),
      .resp_last(resp_last), .query_pending(query_pending));
   sml_host_model sml_host_model_i (.core_clk(core_clk), .rxd(rxd), .txd(txd));
   // ***************
   // helpers
   // ***************
   task automatic summarize;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         errors++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask
   // ceiling: five frames of 21700 cycles plus slack
   always @(posedge core_clk) begin
      cycles++;
      if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
         toks.push_back(cmd_token);
      end
      if (cycles == 120000) begin
         errors++;
         summarize();
      end
   end
   // ***************
   // scenarios
   // ***************
   task automatic t_refuse;
      @(posedge core_clk);
      resp_valid <= 1'b1;
      resp_data <= 7'h5A;
      resp_last <= 1'b1;
      repeat (40) begin
         // look at settled outputs, away from the launching edge
         @(negedge core_clk);
         chk(resp_ready === 1'b0 && txd === 1'b1, "unsolicited send");
      end
      @(posedge core_clk);
      resp_valid <= 1'b0;
   endtask
   task automatic t_query;
      sml_host_model_i.send_char(sml_pkg::CHAR_QMARK);
      sml_host_model_i.send_char(sml_pkg::CHAR_LF);
      repeat (20) @(posedge core_clk);
      chk(query_pending === 1'b1, "query not flagged");
      cmd_ready <= 1'b1;
      repeat (20) @(posedge core_clk);
      cmd_ready <= 1'b0;
      chk(toks.size() == 2, "token count");
      if (toks.size() == 2) begin
         chk(toks[0].kind === sml_pkg::SML_TOK_CHAR, "first kind");
         chk(toks[0].query === 1'b1, "first query bit");
         chk(toks[0].data === sml_pkg::CHAR_QMARK, "first data");
         chk(toks[1].kind === sml_pkg::SML_TOK_END, "end kind");
         chk(toks[1].query === 1'b1, "end query bit");
         chk(toks[1].error === 1'b0, "end error bit");
      end
   endtask
   task automatic t_resp;
      int n;
      n = 0;
      @(posedge core_clk);
      resp_valid <= 1'b1;
      resp_data <= 7'h4B;
      resp_last <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (resp_ready !== 1'b1 && n < 10);
      resp_valid <= 1'b0;
      chk(n < 10, "response not taken");
      n = 0;
      while (sml_host_model_i.got.size() < 3 && n < 70000) begin
         @(posedge core_clk);
         n++;
      end
      chk(sml_host_model_i.got.size() == 3, "frame count");
      if (sml_host_model_i.got.size() == 3) begin
         chk(sml_host_model_i.got[0] === 7'h4B, "response char");
         chk(sml_host_model_i.got[1] === sml_pkg::CHAR_CR, "cr missing");
         chk(sml_host_model_i.got[2] === sml_pkg::CHAR_LF, "lf missing");
      end
      chk(sml_host_model_i.bad === 1'b0, "bad framing or parity");
      repeat (2000) @(posedge core_clk);
      chk(query_pending === 1'b0, "query still pending");
   endtask
   initial begin
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_refuse();
      // one message a run, so the host stays silent after it
      t_query();
      t_resp();
      t_refuse();
      summarize();
   end
endmodule
`default_nettype wire
